// ===== rtrac_pkg.sv
package rtrac_pkg;
  // register offsets, shared set
  localparam logic [7:0] SH_STRAP_OBSERVE = 8'h00;
  localparam logic [7:0] SH_REVISION_VARIANT = 8'h01;
  localparam logic [7:0] SH_SOFT_RESET = 8'h04;
  localparam logic [7:0] SH_IRQ_FLAGS = 8'h05;
  localparam logic [7:0] SH_DIAG_CONTROL = 8'h06;
  localparam logic [7:0] REG_SET_SELECT = 8'hff;
  // register offsets, channel set
  localparam logic [7:0] CH_SOFT_RESET = 8'h00;
  localparam logic [7:0] CH_CDR_OVERRIDE = 8'h0a;
  localparam logic [7:0] CH_RATE_SUBRATE = 8'h2f;
  localparam logic [7:0] CH_ADAPT_MODE = 8'h31;
  // field positions
  localparam int SH_RESET_BIT = 6;
  localparam int CH_RESET_BIT = 2;
  localparam int CDR_OVR_EN_BIT = 3;
  localparam int CDR_OVR_RST_BIT = 2;
  localparam int IRQ_A_BIT = 3;
  localparam int IRQ_B_BIT = 2;
  localparam int SEL_BCAST_BIT = 3;
  localparam int SEL_CHAN_BIT = 2;
  localparam int ADAPT_LSB = 5;
  localparam int RATE_LSB = 4;
  // values
  localparam logic [3:0] DIAG_STRAP_KEY = 4'ha;
  localparam logic [7:0] SMB_WRITE_BASE = 8'h30;
  localparam logic [7:0] RATE_SUBRATE_RESET = 8'h60;
  localparam logic [7:0] REG_RESET = 8'h00;
  // arbitrary identification values, not those of any real part
  localparam logic [3:0] DEV_REVISION = 4'h1;
  localparam logic [3:0] DEV_VARIANT = 4'h2;
  // divide index: 0 = /1, 1 = /2, 2 = /4, 3 = /8
  localparam logic [1:0] DIV_IDX_TOP = 2'h3;

  function automatic logic [7:0] rtrac_chan_default(input logic [7:0] a);
    return (a == CH_RATE_SUBRATE) ? RATE_SUBRATE_RESET : REG_RESET;
  endfunction
endpackage

// ===== rtrac_rate_search.sv
`timescale 1ns/10ps
module rtrac_rate_search import rtrac_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] rate_subrate_i,
  input wire logic restart_i,
  input wire logic advance_i,
  output logic [3:0] grp0_div_en_o,
  output logic [3:0] grp1_div_en_o,
  output logic [1:0] search_div_o
);
  logic [7:0] map;
  logic [3:0] any_en;
  logic [1:0] next_search_div;

  // per group: bit0 /1, bit1 /2, bit2 /4, bit3 /8
  function automatic logic [7:0] rtrac_div_map(input logic [3:0] rs);
    unique case (rs)
      4'h0: return 8'h18;
      4'h1: return 8'h17;
      4'h2, 4'h3: return 8'h77;
      4'h4: return 8'h66;
      4'h5: return 8'h55;
      4'h6: return 8'hff;
      4'ha: return 8'h22;
      4'hb: return 8'h66;
      4'hf: return 8'h18;
      default: return 8'h11;
    endcase
  endfunction

  // next enabled ratio below idx, wrapping to the top
  function automatic logic [1:0] rtrac_next_div(input logic [3:0] en, input logic [1:0] idx,
                                                input logic from_top);
    logic [1:0] k;
    k = from_top ? DIV_IDX_TOP : idx - 2'h1;
    for (int n = 0; n < 4; n++) begin
      if (en[k]) begin
        return k;
      end
      k = k - 2'h1;
    end
    return idx;
  endfunction

  assign map = rtrac_div_map(rate_subrate_i);
  assign grp0_div_en_o = map[3:0];
  assign grp1_div_en_o = map[7:4];
  assign any_en = map[3:0] | map[7:4];
  // search runs /8 toward /1
  assign next_search_div = restart_i ? rtrac_next_div(any_en, search_div_o, 1'b1) :
                           advance_i ? rtrac_next_div(any_en, search_div_o, search_div_o == 2'h0) :
                           search_div_o;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      search_div_o <= DIV_IDX_TOP;
    end else begin
      search_div_o <= next_search_div;
    end
  end

  property p_search_down;
    @(posedge clock_i) disable iff (rst_i)
      (advance_i && !restart_i && search_div_o != 2'h0 && any_en[search_div_o - 2'h1])
      |=> search_div_o == $past(search_div_o) - 2'h1;
  endproperty
  a_search_down: assert property (p_search_down) else $error("search did not step down");

  property p_search_enabled;
    @(posedge clock_i) disable iff (rst_i) restart_i |=> any_en[search_div_o];
  endproperty
  a_search_enabled: assert property (p_search_enabled) else $error("search on disabled ratio");
endmodule // rtrac_rate_search

// ===== rtrac_channel_regs.sv
`timescale 1ns/10ps
module rtrac_channel_regs import rtrac_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic cdr_hold_o,
  output logic cdr_restart_o,
  output logic [1:0] adapt_mode_o,
  output logic [3:0] rate_subrate_o
);
  logic [7:0] mem [0:255];
  logic soft_reset;
  logic cdr_hold_q;
  logic [7:0] ovr;

  assign soft_reset = wr_i && addr_i == CH_SOFT_RESET && wdata_i[CH_RESET_BIT];
  assign ovr = mem[CH_CDR_OVERRIDE];
  // held only while both override bits are set
  assign cdr_hold_o = ovr[CDR_OVR_EN_BIT] & ovr[CDR_OVR_RST_BIT];
  // release restarts lock and adaptation
  assign cdr_restart_o = cdr_hold_q & ~cdr_hold_o;
  assign adapt_mode_o = mem[CH_ADAPT_MODE][ADAPT_LSB +: 2];
  assign rate_subrate_o = mem[CH_RATE_SUBRATE][RATE_LSB +: 4];
  assign rdata_o = (addr_i == CH_SOFT_RESET) ? {mem[0][7:3], 1'b0, mem[0][1:0]} : mem[addr_i];

  always_ff @(posedge clock_i) begin
    if (rst_i || soft_reset) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= rtrac_chan_default(8'(i));
      end
    end else if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cdr_hold_q <= 1'b0;
    end else begin
      cdr_hold_q <= cdr_hold_o;
    end
  end

  property p_soft_reset;
    @(posedge clock_i) disable iff (rst_i)
      soft_reset |=> rate_subrate_o == RATE_SUBRATE_RESET[RATE_LSB +: 4] && !mem[0][CH_RESET_BIT];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("channel reset missed");

  property p_cdr_release;
    @(posedge clock_i) disable iff (rst_i) $fell(cdr_hold_o) |-> cdr_restart_o;
  endproperty
  a_cdr_release: assert property (p_cdr_release) else $error("no restart on release");
endmodule // rtrac_channel_regs

// ===== rtrac_register_access_ctrl.sv
`timescale 1ns/10ps
module rtrac_register_access_ctrl import rtrac_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic strap_i,
  input wire logic [7:0] smb_addr_i,
  output logic smb_addr_ack_o,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic irq_a_i,
  input wire logic irq_b_i,
  input wire logic [1:0] advance_i,
  output logic [1:0] cdr_hold_o,
  output logic [1:0] cdr_restart_o,
  output logic [3:0] adapt_mode_o,
  output logic [15:0] div_en_o,
  output logic [3:0] search_div_o
);
  logic [7:0] sh_mem [0:255];
  logic strap;
  logic strap_taken;
  logic [7:0] sel;
  logic is_sel_addr;
  logic chan_mode;
  logic bcast;
  logic rd_chan;
  logic sh_wr;
  logic sh_reset;
  logic [1:0] ch_wr;
  logic [7:0] ch_rdata [0:1];
  logic [7:0] sh_rdata;
  logic strap_visible;
  logic [7:0] next_rdata;
  logic [3:0] rs_field [0:1];

  // strap capture on the first edge after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      strap <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap <= strap_i;
      strap_taken <= 1'b1;
    end
  end

  // strap moves the address by one step above the write base
  assign smb_addr_ack_o = strap_taken && smb_addr_i[7:1] == (SMB_WRITE_BASE[7:1] + {6'h0, strap})
                          && !smb_addr_i[0];

  // routing decode
  assign sel = sh_mem[REG_SET_SELECT];
  assign is_sel_addr = reg_addr_i == REG_SET_SELECT;
  assign chan_mode = sel[SEL_CHAN_BIT] && !is_sel_addr;
  assign bcast = sel[SEL_BCAST_BIT];
  // bit 1 ignored so undefined codes fall on A or B
  assign rd_chan = sel[0];
  assign sh_wr = reg_wr_i && !chan_mode;
  assign sh_reset = sh_wr && reg_addr_i == SH_SOFT_RESET && reg_wdata_i[SH_RESET_BIT];
  assign ch_wr[0] = reg_wr_i && chan_mode && (bcast || !rd_chan);
  assign ch_wr[1] = reg_wr_i && chan_mode && (bcast || rd_chan);

  // shared set, with read-only and self-clearing locations
  always_ff @(posedge clock_i) begin
    if (rst_i || sh_reset) begin
      for (int i = 0; i < 256; i++) begin
        sh_mem[i] <= REG_RESET;
      end
    end else if (sh_wr) begin
      sh_mem[reg_addr_i] <= reg_wdata_i;
    end
  end

  assign strap_visible = sh_mem[SH_DIAG_CONTROL][3:0] == DIAG_STRAP_KEY;

  always_comb begin
    unique case (reg_addr_i)
      SH_STRAP_OBSERVE: begin
        sh_rdata = {strap_visible ? {3'h0, strap} : sh_mem[0][7:4], sh_mem[0][3:0]};
      end
      SH_REVISION_VARIANT: begin
        sh_rdata = {DEV_VARIANT, DEV_REVISION};
      end
      SH_SOFT_RESET: begin
        sh_rdata = sh_mem[SH_SOFT_RESET] & 8'hbf;
      end
      SH_IRQ_FLAGS: begin
        sh_rdata = 8'h00;
        sh_rdata[IRQ_A_BIT] = irq_a_i;
        sh_rdata[IRQ_B_BIT] = irq_b_i;
      end
      default: begin
        sh_rdata = sh_mem[reg_addr_i];
      end
    endcase
  end

  assign next_rdata = chan_mode ? ch_rdata[rd_chan] : sh_rdata;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // defaults of 0110 enable /1../8 for both groups
  for (genvar c = 0; c < 2; c++) begin : g_chan
    rtrac_channel_regs u_regs (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_i(ch_wr[c]),
      .addr_i(reg_addr_i),
      .wdata_i(reg_wdata_i),
      .rdata_o(ch_rdata[c]),
      .cdr_hold_o(cdr_hold_o[c]),
      .cdr_restart_o(cdr_restart_o[c]),
      .adapt_mode_o(adapt_mode_o[2*c +: 2]),
      .rate_subrate_o(rs_field[c])
    );
    rtrac_rate_search u_search (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .rate_subrate_i(rs_field[c]),
      .restart_i(cdr_restart_o[c]),
      .advance_i(advance_i[c] && !cdr_hold_o[c]),
      .grp0_div_en_o(div_en_o[8*c +: 4]),
      .grp1_div_en_o(div_en_o[8*c + 4 +: 4]),
      .search_div_o(search_div_o[2*c +: 2])
    );
  end

  // checks
  property p_strap_view;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && !chan_mode && reg_addr_i == SH_STRAP_OBSERVE && strap_visible)
      |=> reg_rdata_o[7:4] == {3'h0, strap};
  endproperty
  a_strap_view: assert property (p_strap_view) else $error("strap not visible");

  property p_strap_stable;
    @(posedge clock_i) disable iff (rst_i) strap_taken |=> $stable(strap);
  endproperty
  a_strap_stable: assert property (p_strap_stable) else $error("strap changed");

  property p_addr_ack;
    @(posedge clock_i) disable iff (rst_i)
      (strap_taken && !strap && smb_addr_i == SMB_WRITE_BASE) |-> smb_addr_ack_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no ack at write base");

  property p_sh_reset;
    @(posedge clock_i) disable iff (rst_i) sh_reset |=> sel == REG_RESET && !sh_mem[4][6];
  endproperty
  a_sh_reset: assert property (p_sh_reset) else $error("shared reset missed");

  property p_ident;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && !chan_mode && reg_addr_i == SH_REVISION_VARIANT)
      |=> reg_rdata_o == {DEV_VARIANT, DEV_REVISION};
  endproperty
  a_ident: assert property (p_ident) else $error("bad identification read");

  property p_bcast;
    @(posedge clock_i) disable iff (rst_i) (reg_wr_i && chan_mode && bcast) |-> &ch_wr;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast write missed a channel");

  property p_chan_read;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && chan_mode) |=> reg_rdata_o == $past(ch_rdata[rd_chan]);
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("wrong channel read");

  property p_shared_safe;
    @(posedge clock_i) disable iff (rst_i) (reg_wr_i && chan_mode) |=> $stable(sel);
  endproperty
  a_shared_safe: assert property (p_shared_safe) else $error("shared set touched");

  property p_sel_write;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && is_sel_addr) |=> sel == $past(reg_wdata_i) && $past(ch_wr) == 2'b00;
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write misrouted");

  property p_single_a;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && !is_sel_addr && sel == 8'h04) |-> ch_wr == 2'b01 && !sh_wr;
  endproperty
  a_single_a: assert property (p_single_a) else $error("0x04 did not target A");

  property p_irq_flags;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && !chan_mode && reg_addr_i == SH_IRQ_FLAGS)
      |=> reg_rdata_o[IRQ_A_BIT] == $past(irq_a_i) && reg_rdata_o[IRQ_B_BIT] == $past(irq_b_i);
  endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("interrupt flags wrong");

  property p_rvalid_pulse;
    @(posedge clock_i) disable iff (rst_i)
      reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  property p_rvalid_idle;
    @(posedge clock_i) disable iff (rst_i)
      !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("stray read valid");

  property p_rdata_hold;
    @(posedge clock_i) disable iff (rst_i)
      !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_sel_read;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && is_sel_addr) |=> reg_rdata_o == $past(sel);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read misrouted");

  property p_strap_hidden;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && !chan_mode && reg_addr_i == SH_STRAP_OBSERVE && !strap_visible)
      |=> reg_rdata_o == $past(sh_mem[SH_STRAP_OBSERVE]);
  endproperty
  a_strap_hidden: assert property (p_strap_hidden) else $error("strap shown without key");

  property p_single_b;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && !is_sel_addr && sel == 8'h05) |-> ch_wr == 2'b10 && !sh_wr;
  endproperty
  a_single_b: assert property (p_single_b) else $error("0x05 did not target B");

  property p_shared_route;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && !is_sel_addr && sel == 8'h00) |-> ch_wr == 2'b00 && sh_wr;
  endproperty
  a_shared_route: assert property (p_shared_route) else $error("0x00 left shared set");

  property p_bcast_b;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && !is_sel_addr && sel == 8'h0d) |-> ch_wr == 2'b11 && !sh_wr;
  endproperty
  a_bcast_b: assert property (p_bcast_b) else $error("0x0d write missed a channel");

  property p_bcast_read;
    @(posedge clock_i) disable iff (rst_i)
      (reg_rd_i && !is_sel_addr && sel == 8'h0d) |=> reg_rdata_o == $past(ch_rdata[1]);
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("0x0d read not from B");

  property p_undef_a;
    @(posedge clock_i) disable iff (rst_i)
      (reg_wr_i && !is_sel_addr && sel == 8'h06) |-> ch_wr == 2'b01 && !sh_wr;
  endproperty
  a_undef_a: assert property (p_undef_a) else $error("undefined select hit shared set");

  property p_hold_a;
    @(posedge clock_i) disable iff (rst_i)
      cdr_hold_o[0] |=> $stable(search_div_o[1:0]);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("held channel A searched");

  property p_hold_b;
    @(posedge clock_i) disable iff (rst_i)
      cdr_hold_o[1] |=> $stable(search_div_o[3:2]);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("held channel B searched");

  property p_restart_top;
    @(posedge clock_i) disable iff (rst_i)
      (cdr_restart_o[0] && !div_en_o[3] && !div_en_o[7]) |=> search_div_o[1:0] != DIV_IDX_TOP;
  endproperty
  a_restart_top: assert property (p_restart_top) else $error("restart on disabled /8");

  property p_ack_write;
    @(posedge clock_i) disable iff (rst_i)
      smb_addr_ack_o |-> !smb_addr_i[0];
  endproperty
  a_ack_write: assert property (p_ack_write) else $error("ack on read address");
endmodule // rtrac_register_access_ctrl

// ===== rtrac_host_model.sv
`timescale 1ns/10ps
module rtrac_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // always a whole byte, select writes included
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    // released bus shows no stale value
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule // rtrac_host_model

// ===== rtrac_register_access_ctrl_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module rtrac_register_access_ctrl_test import rtrac_pkg::*; ();
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap_i = 1'b1;
  logic strap_cap = 1'b1;
  logic [7:0] smb_addr_i = 8'h00;
  logic irq_a_i = 1'b0;
  logic irq_b_i = 1'b0;
  logic [1:0] advance_i = 2'b00;
  logic reg_wr_i, reg_rd_i, smb_addr_ack_o, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] cdr_hold_o, cdr_restart_o, av, sa, sb;
  logic [3:0] adapt_mode_o, search_div_o;
  logic [15:0] div_en_o;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] sh [256];
  logic [7:0] ch [2][256];
  logic [63:0] g0_tab = 64'h8111_6211_1f56_7778;
  logic [63:0] g1_tab = 64'h1111_6211_1f56_7711;
  // last two codes are undefined
  logic [7:0] sel_tab [7] = '{8'h00, 8'h04, 8'h05, 8'h0c, 8'h0d, 8'h06, 8'h0e};

  always #5 clock_i = ~clock_i;

  rtrac_register_access_ctrl dut (.clock_i(clock_i), .rst_i(rst_i), .strap_i(strap_i),
    .smb_addr_i(smb_addr_i), .smb_addr_ack_o(smb_addr_ack_o), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .irq_a_i(irq_a_i),
    .irq_b_i(irq_b_i), .advance_i(advance_i), .cdr_hold_o(cdr_hold_o),
    .cdr_restart_o(cdr_restart_o), .adapt_mode_o(adapt_mode_o), .div_en_o(div_en_o),
    .search_div_o(search_div_o));

  rtrac_host_model host (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic m_chrst(input int c);
    for (int i = 0; i < 256; i++)
      ch[c][i] = (i == 'h2f) ? 8'h60 : 8'h00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    if (a == REG_SET_SELECT)
      sh[255] = d;
    else if (!sh[255][2] && a == SH_SOFT_RESET && d[6])
      foreach (sh[i]) sh[i] = 8'h00;
    else if (!sh[255][2])
      sh[a] = d;
    else
      for (int c = 0; c < 2; c++)
        if (sh[255][3] || c == int'(sh[255][0]))
          if (a == CH_SOFT_RESET && d[2])
            m_chrst(c);
          else
            ch[c][a] = d;
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] d, e, m;
    logic v;
    m = 8'hff;
    if (a == REG_SET_SELECT)
      e = sh[255];
    else if (sh[255][2])
      e = ch[sh[255][0]][a];
    else begin
      e = sh[a];
      if (a == SH_STRAP_OBSERVE && sh[6][3:0] == DIAG_STRAP_KEY)
        e[7:4] = {3'h0, strap_cap};
      if (a == SH_REVISION_VARIANT)
        e = {DEV_VARIANT, DEV_REVISION};
      if (a == SH_IRQ_FLAGS) begin
        e = {4'h0, irq_a_i, irq_b_i, 2'h0};
        m = 8'h0c;
      end
    end
    host.read(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d & m, e & m)
  endtask

  task automatic chk_all();
    foreach (sel_tab[i]) begin
      wr(REG_SET_SELECT, sel_tab[i]);
      rd(REG_SET_SELECT);
      rd(CH_ADAPT_MODE);
      rd(SH_DIAG_CONTROL);
      rd(CH_RATE_SUBRATE);
      rd(SH_SOFT_RESET);
    end
  endtask

  task automatic power_up(input logic s);
    strap_i <= s;
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    strap_i <= ~s;
    strap_cap = s;
    foreach (sh[i]) sh[i] = 8'h00;
    m_chrst(0);
    m_chrst(1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_i);
      smb_addr_i <= SMB_WRITE_BASE + 8'(k);
      #1;
      `CHK(smb_addr_ack_o, 1'(k == 2 * s))
    end
    wr(SH_DIAG_CONTROL, 8'h0a);
    rd(SH_STRAP_OBSERVE);
  endtask

  function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] m);
    for (int j = 1; j < 5; j++)
      if (m[2'(c - j)])
        return 2'(c - j);
    return c;
  endfunction

  initial begin
    void'($urandom(15115));
    power_up(1'b1);
    `CHK(search_div_o, 4'hf)
    @(posedge clock_i);
    {irq_a_i, irq_b_i} <= 2'($urandom);
    @(posedge clock_i);
    rd(SH_IRQ_FLAGS);
    rd(SH_REVISION_VARIANT);
    for (int r = 0; r < 12; r++) begin
      wr(REG_SET_SELECT, sel_tab[$urandom_range(6)]);
      wr(r[0] ? CH_ADAPT_MODE : SH_DIAG_CONTROL, 8'($urandom));
      chk_all();
    end
    #1;
    `CHK(adapt_mode_o, {ch[1][8'h31][6:5], ch[0][8'h31][6:5]})
    wr(REG_SET_SELECT, 8'h05);
    wr(CH_SOFT_RESET, 8'h04);
    chk_all();
    wr(REG_SET_SELECT, 8'h00);
    wr(SH_SOFT_RESET, 8'h40);
    chk_all();
    wr(REG_SET_SELECT, 8'h0c);
    for (int k = 0; k < 16; k++) begin
      wr(CH_RATE_SUBRATE, {4'(k), 4'($urandom)});
      #1;
      `CHK(div_en_o, {2{g1_tab[4*k+:4], g0_tab[4*k+:4]}})
    end
    // only /4 and /1 enabled
    wr(CH_RATE_SUBRATE, 8'h50);
    wr(REG_SET_SELECT, 8'h04);
    wr(CH_CDR_OVERRIDE, 8'h0c);
    #1;
    `CHK(cdr_hold_o, 2'b01)
    wr(CH_CDR_OVERRIDE, 8'h00);
    #1;
    `CHK(cdr_restart_o, 2'b01)
    @(posedge clock_i);
    #1;
    sa = 2'd2;
    sb = 2'd3;
    `CHK(search_div_o, {sb, sa})
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      av = 2'($urandom);
      advance_i <= av;
      @(posedge clock_i);
      advance_i <= 2'b00;
      sa = av[0] ? nxt(sa, 4'h5) : sa;
      sb = av[1] ? nxt(sb, 4'h5) : sb;
      #1;
      `CHK(search_div_o, {sb, sa})
    end
    power_up(1'b0);
    test_done();
  end
endmodule // rtrac_register_access_ctrl_test
